// ===== design/uart_mdb.sv
// buffer, status and address filter of a multidrop serial port
// Overview of operation
// - filter mode drops data frames from buffer
// - type from first stop, or ninth bit
// - type one is address, zero data
// - transmitter ignores the filter mode bit
// - one data address: write tx, read rx
// - short characters: upper bits ignored, read zero
// - data writes dropped while buffer not empty
// - buffer moves to shifter when shifter empty and transmitter enabled
// - two-entry receive fifo advances per data read
// - rx complete high while buffer holds data
// - tx complete on frame out with buffer empty, cleared by one
// - buffer empty flag one when writable, reset
// - frame error flag follows buffer head
// - overrun when full, held, new start
// - parity error only when checking was enabled
// - double speed divides by eight, not sixteen
// - interrupt needs enable, global flag, status flag
// - receiver disable flushes buffer and errors
// - filter mode bit zero of status a
// - ninth bit read and written before low
// - size codes five to eight, seven nine
`timescale 1ns/1ps
module uart_mdb (
	input wire logic mclk,
	input wire logic resetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// receive sampler side
	input wire logic rx_start_detect,
	input wire logic rx_frame_valid,
	input wire uart_mdb_pkg::rx_frame_t rx_frame,
	output logic rx_pin_enable,
	output logic rx_sample_tick,
	// transmit pin
	output logic txd,
	output logic tx_pin_enable,
	// interrupt requests towards the cpu
	input wire logic global_irq_enable,
	input wire logic tx_complete_irq_ack,
	output logic rx_complete_irq,
	output logic tx_complete_irq,
	output logic tx_empty_irq
);
	// all state of the block
	typedef struct packed {
		logic [7:0] control_b;
		logic [7:0] control_c;
		logic [11:0] baud;
		logic double_speed;
		logic addr_filter_mode;
		logic tx_complete_flag;
		logic overrun_flag;
		uart_mdb_pkg::rx_entry_t [1:0] rx_buffer;
		logic [1:0] rx_count;
		uart_mdb_pkg::rx_entry_t rx_hold;
		logic rx_hold_valid;
		logic [8:0] tx_buffer;
		logic tx_full;
		logic [11:0] presc;
		logic [3:0] sub;
		logic sample_tick;
		logic bit_tick;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} state_t;

	state_t s;
	state_t next_s;

	// character size code from both control registers
	logic [2:0] char_size_code;
	logic nine_bit;
	logic receiver_enable;
	logic tx_enable;
	// transmit shifter handshakes
	logic shift_busy;
	logic shift_done;
	logic shift_load;
	uart_mdb_pkg::tx_req_t shift_req;
	// bus strobes
	logic wr_fire;
	logic rd_fire;
	// derived receive entry
	uart_mdb_pkg::rx_entry_t rx_new;
	logic frame_type;
	logic frame_keep;
	logic tx_buffer_empty_flag;
	logic rx_complete_flag;

	// data bits of a size code; reserved codes behave as eight
	function automatic logic [3:0] size_bits(input logic [2:0] code);
		case (code)
			3'h0: size_bits = 4'h5;
			3'h1: size_bits = 4'h6;
			3'h2: size_bits = 4'h7;
			uart_mdb_pkg::SIZE_9: size_bits = 4'h9;
			default: size_bits = 4'h8;
		endcase
	endfunction

	// clear the bits above the character width
	function automatic logic [8:0] size_mask(input logic [8:0] d, input logic [2:0] code);
		logic [8:0] m;
		m = 9'h1ff >> (4'h9 - size_bits(code));
		size_mask = d & m;
	endfunction

	assign char_size_code = {s.control_b[uart_mdb_pkg::CB_SIZE2],
		s.control_c[uart_mdb_pkg::CC_SIZE_LO +: 2]};
	assign nine_bit = (char_size_code == uart_mdb_pkg::SIZE_9);
	assign receiver_enable = s.control_b[uart_mdb_pkg::CB_RXEN];
	assign tx_enable = s.control_b[uart_mdb_pkg::CB_TXEN];
	assign tx_buffer_empty_flag = !s.tx_full;
	assign rx_complete_flag = (s.rx_count != 2'h0);

	// bus handshakes: write needs address and data together
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = !s.rvalid;
	assign wr_fire = s_axi_awready;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// frame type and the filter decision, made before any push
	always_comb begin
		rx_new.data = size_mask(rx_frame.data, char_size_code);
		rx_new.fe = !rx_frame.stop_bit;
		// mismatch only counts while checking is enabled
		rx_new.pe = s.control_c[uart_mdb_pkg::CC_PAR_EN] &&
			(^rx_new.data ^ rx_frame.parity_bit ^
			s.control_c[uart_mdb_pkg::CC_PAR_ODD]);
		frame_type = nine_bit ? rx_frame.data[8] : rx_frame.stop_bit;
		// data frames (type zero) are dropped in filter mode
		frame_keep = !(s.addr_filter_mode && !frame_type);
	end

	// shifter request; the filter bit plays no part here
	always_comb begin
		shift_req.data = s.tx_buffer;
		shift_req.nbits = size_bits(char_size_code);
		shift_req.par_en = s.control_c[uart_mdb_pkg::CC_PAR_EN];
		shift_req.par_odd = s.control_c[uart_mdb_pkg::CC_PAR_ODD];
		shift_req.two_stop = s.control_c[uart_mdb_pkg::CC_STOP2];
		shift_load = s.tx_full && tx_enable && !shift_busy;
	end

	// next state of the whole block
	always_comb begin
		next_s = s;
		next_s.sample_tick = 1'b0;
		next_s.bit_tick = 1'b0;

		// baud prescaler, then 16 or 8 samples per bit
		if (s.presc == 12'h000) begin
			next_s.presc = s.baud;
			next_s.sample_tick = 1'b1;
			if (s.sub == 4'h0) begin
				next_s.sub = s.double_speed ? uart_mdb_pkg::SAMPLES_DOUBLE_M1
					: uart_mdb_pkg::SAMPLES_NORMAL_M1;
				next_s.bit_tick = 1'b1;
			end else begin
				next_s.sub = s.sub - 4'h1;
			end
		end else begin
			next_s.presc = s.presc - 12'h001;
		end

		// transmit buffer hands over to the shifter
		if (shift_load) begin
			next_s.tx_full = 1'b0;
		end

		// write response completes
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		// read response completes
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// transmit complete clears by service or by writing one
		if (tx_complete_irq_ack) begin
			next_s.tx_complete_flag = 1'b0;
		end

		// register writes
		if (wr_fire) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = uart_mdb_pkg::RESP_OKAY;
			if (s_axi_wstrb[0]) begin
				case (s_axi_awaddr)
					uart_mdb_pkg::OFS_DATA: begin
						// dropped unless the buffer is empty
						if (tx_buffer_empty_flag) begin
							// ninth bit comes from control_b, written first
							next_s.tx_buffer = size_mask({s.control_b[uart_mdb_pkg::CB_TXB8],
								s_axi_wdata[7:0]}, char_size_code);
							next_s.tx_full = 1'b1;
						end
					end
					uart_mdb_pkg::OFS_STATUS_A: begin
						if (s_axi_wdata[uart_mdb_pkg::SA_TXC]) begin
							next_s.tx_complete_flag = 1'b0;
						end
						next_s.double_speed = s_axi_wdata[uart_mdb_pkg::SA_U2X];
						next_s.addr_filter_mode = s_axi_wdata[uart_mdb_pkg::SA_MPCM];
					end
					uart_mdb_pkg::OFS_CONTROL_B: begin
						// receive ninth bit is read only
						next_s.control_b = s_axi_wdata[7:0] &
							~(8'h01 << uart_mdb_pkg::CB_RXB8);
					end
					uart_mdb_pkg::OFS_CONTROL_C: begin
						next_s.control_c = s_axi_wdata[7:0] & 8'h3e;
					end
					uart_mdb_pkg::OFS_BAUD: begin
						next_s.baud = s_axi_wdata[11:0];
						// new rate takes effect at once
						next_s.presc = s_axi_wdata[11:0];
					end
					default: next_s.bresp = uart_mdb_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_awaddr > uart_mdb_pkg::OFS_BAUD || s_axi_awaddr[1:0] != 2'h0) begin
				next_s.bresp = uart_mdb_pkg::RESP_SLVERR;
			end
		end

		// frame fully sent and nothing left to send
		if (shift_done && !s.tx_full) begin
			next_s.tx_complete_flag = 1'b1;
		end

		// hold register drains into the fifo when room appears
		if (s.rx_hold_valid && s.rx_count != 2'h2) begin
			next_s.rx_buffer[s.rx_count[0]] = s.rx_hold;
			next_s.rx_count = s.rx_count + 2'h1;
			next_s.rx_hold_valid = 1'b0;
		end

		// new frame from the sampler; filter decided first
		if (rx_frame_valid && receiver_enable && frame_keep) begin
			if (next_s.rx_count != 2'h2) begin
				next_s.rx_buffer[next_s.rx_count[0]] = rx_new;
				next_s.rx_count = next_s.rx_count + 2'h1;
			end else if (!next_s.rx_hold_valid) begin
				next_s.rx_hold = rx_new;
				next_s.rx_hold_valid = 1'b1;
			end
		end

		// register reads; a data read pops the fifo
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = uart_mdb_pkg::RESP_OKAY;
			next_s.rdata = 8'h00;
			case (s_axi_araddr)
				uart_mdb_pkg::OFS_DATA: begin
					next_s.rdata = s.rx_buffer[0].data[7:0];
					// every read moves the fifo, bit tests too
					if (s.rx_count != 2'h0) begin
						// pop after any push of this cycle so no frame is lost
						next_s.rx_buffer[0] = next_s.rx_buffer[1];
						next_s.rx_buffer[1] = '0;
						next_s.rx_count = next_s.rx_count - 2'h1;
						// the hold entry moves up into the freed slot, once
						if (next_s.rx_hold_valid && s.rx_count == 2'h2) begin
							next_s.rx_buffer[1] = next_s.rx_hold;
							next_s.rx_count = 2'h2;
							next_s.rx_hold_valid = 1'b0;
						end
					end
					next_s.overrun_flag = 1'b0;
				end
				uart_mdb_pkg::OFS_STATUS_A: begin
					next_s.rdata[uart_mdb_pkg::SA_RXC] = rx_complete_flag;
					next_s.rdata[uart_mdb_pkg::SA_TXC] = s.tx_complete_flag;
					next_s.rdata[uart_mdb_pkg::SA_UDRE] = tx_buffer_empty_flag;
					next_s.rdata[uart_mdb_pkg::SA_FE] = rx_complete_flag && s.rx_buffer[0].fe;
					next_s.rdata[uart_mdb_pkg::SA_DOR] = s.overrun_flag;
					next_s.rdata[uart_mdb_pkg::SA_UPE] = rx_complete_flag && s.rx_buffer[0].pe;
					next_s.rdata[uart_mdb_pkg::SA_U2X] = s.double_speed;
					next_s.rdata[uart_mdb_pkg::SA_MPCM] = s.addr_filter_mode;
				end
				uart_mdb_pkg::OFS_CONTROL_B: begin
					next_s.rdata = s.control_b;
					// ninth bit of the head entry, read before the data
					next_s.rdata[uart_mdb_pkg::CB_RXB8] = s.rx_buffer[0].data[8];
				end
				uart_mdb_pkg::OFS_CONTROL_C: next_s.rdata = s.control_c;
				uart_mdb_pkg::OFS_BAUD: next_s.rdata = s.baud[7:0];
				default: next_s.rresp = uart_mdb_pkg::RESP_SLVERR;
			endcase
		end

		// overrun: fifo full, hold full, new start bit; set wins
		if (rx_start_detect && receiver_enable && s.rx_count == 2'h2 && s.rx_hold_valid) begin
			next_s.overrun_flag = 1'b1;
		end

		// disabled receiver flushes buffer and error flags
		if (!receiver_enable) begin
			next_s.rx_count = 2'h0;
			next_s.rx_buffer = '0;
			next_s.rx_hold_valid = 1'b0;
			next_s.overrun_flag = 1'b0;
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.control_b <= uart_mdb_pkg::RST_CONTROL_B;
			s.control_c <= uart_mdb_pkg::RST_CONTROL_C;
			s.baud <= uart_mdb_pkg::RST_BAUD;
			s.sub <= uart_mdb_pkg::SAMPLES_NORMAL_M1;
		end else begin
			s <= next_s;
		end
	end

	// transmit shift register
	uart_tx_shifter u_tx_shifter (
		.mclk(mclk),
		.resetn(resetn),
		.bit_tick(s.bit_tick),
		.load(shift_load),
		.req(shift_req),
		.txd(txd),
		.busy(shift_busy),
		.done(shift_done)
	);

	// interrupt requests gated by enable, global flag and status
	assign rx_complete_irq = s.control_b[uart_mdb_pkg::CB_RXCIE] && global_irq_enable
		&& rx_complete_flag;
	assign tx_complete_irq = s.control_b[uart_mdb_pkg::CB_TXCIE] && global_irq_enable
		&& s.tx_complete_flag;
	assign tx_empty_irq = s.control_b[uart_mdb_pkg::CB_UDRIE] && global_irq_enable
		&& tx_buffer_empty_flag;

	// rx pin follows its enable; tx pin follows its enable, shifter busy or buffer full
	assign rx_pin_enable = receiver_enable;
	assign tx_pin_enable = tx_enable || shift_busy || s.tx_full;
	assign rx_sample_tick = s.sample_tick;

	// bus outputs
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = {24'h000000, s.rdata};
endmodule // uart_mdb

// ===== design/uart_mdb_pkg.sv
// shared constants and types of the multidrop serial buffer/status block
package uart_mdb_pkg;
	// register byte addresses
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_STATUS_A = 8'h04;
	localparam logic [7:0] OFS_CONTROL_B = 8'h08;
	localparam logic [7:0] OFS_CONTROL_C = 8'h0c;
	localparam logic [7:0] OFS_BAUD = 8'h10;
	// status_a fields
	localparam int SA_RXC = 7;
	localparam int SA_TXC = 6;
	localparam int SA_UDRE = 5;
	localparam int SA_FE = 4;
	localparam int SA_DOR = 3;
	localparam int SA_UPE = 2;
	localparam int SA_U2X = 1;
	localparam int SA_MPCM = 0;
	// control_b fields
	localparam int CB_RXCIE = 7;
	localparam int CB_TXCIE = 6;
	localparam int CB_UDRIE = 5;
	localparam int CB_RXEN = 4;
	localparam int CB_TXEN = 3;
	localparam int CB_SIZE2 = 2;
	localparam int CB_RXB8 = 1;
	localparam int CB_TXB8 = 0;
	// control_c fields: size low bits, stop select, parity mode
	localparam int CC_SIZE_LO = 1;
	localparam int CC_STOP2 = 3;
	localparam int CC_PAR_ODD = 4;
	localparam int CC_PAR_EN = 5;
	// reset values
	localparam logic [7:0] RST_CONTROL_B = 8'h00;
	localparam logic [7:0] RST_CONTROL_C = 8'h06;
	localparam logic [11:0] RST_BAUD = 12'h000;
	// character size codes
	localparam logic [2:0] SIZE_9 = 3'h7;
	// samples per bit, normal and double speed
	localparam logic [3:0] SAMPLES_NORMAL_M1 = 4'hf;
	localparam logic [3:0] SAMPLES_DOUBLE_M1 = 4'h7;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one frame handed over by the receive sampler
	typedef struct packed {
		logic [8:0] data;
		logic stop_bit;
		logic parity_bit;
	} rx_frame_t;

	// one receive buffer entry with its error flags
	typedef struct packed {
		logic [8:0] data;
		logic fe;
		logic pe;
	} rx_entry_t;

	// frame format handed to the transmit shifter
	typedef struct packed {
		logic [8:0] data;
		logic [3:0] nbits;
		logic par_en;
		logic par_odd;
		logic two_stop;
	} tx_req_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
endpackage

// ===== design/uart_tx_shifter.sv
// transmit shift register: serialises one frame per load
`timescale 1ns/1ps
module uart_tx_shifter (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic bit_tick,
	input wire logic load,
	input wire uart_mdb_pkg::tx_req_t req,
	output logic txd,
	output logic busy,
	output logic done
);
	// shifter state
	typedef struct packed {
		uart_mdb_pkg::tx_state_t st;
		uart_mdb_pkg::tx_req_t cur;
		logic [3:0] cnt;
		logic par;
		logic line;
		logic done;
	} shift_t;

	shift_t s;
	shift_t next_s;

	// next state: each bit stands for one bit tick
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		case (s.st)
			uart_mdb_pkg::TX_IDLE: begin
				next_s.line = 1'b1;
				if (load) begin
					// upper unused bits already masked by the caller
					next_s.cur = req;
					next_s.par = req.par_odd;
					next_s.cnt = 4'h0;
					next_s.st = uart_mdb_pkg::TX_START;
				end
			end
			uart_mdb_pkg::TX_START: begin
				if (bit_tick) begin
					next_s.line = 1'b0;
					next_s.st = uart_mdb_pkg::TX_DATA;
				end
			end
			uart_mdb_pkg::TX_DATA: begin
				if (bit_tick) begin
					next_s.line = s.cur.data[0];
					next_s.par = s.par ^ s.cur.data[0];
					next_s.cur.data = {1'b0, s.cur.data[8:1]};
					next_s.cnt = s.cnt + 4'h1;
					if (s.cnt + 4'h1 == s.cur.nbits) begin
						// counter restarts to count the stop periods
						next_s.cnt = 4'h0;
						next_s.st = s.cur.par_en ? uart_mdb_pkg::TX_PARITY
							: uart_mdb_pkg::TX_STOP;
					end
				end
			end
			uart_mdb_pkg::TX_PARITY: begin
				if (bit_tick) begin
					next_s.line = s.par;
					next_s.st = uart_mdb_pkg::TX_STOP;
				end
			end
			uart_mdb_pkg::TX_STOP: begin
				if (bit_tick) begin
					next_s.line = 1'b1;
					next_s.cnt = s.cnt + 4'h1;
					// frame is out only when the last stop period has ended
					if (s.cnt == {3'h0, s.cur.two_stop} + 4'h1) begin
						next_s.st = uart_mdb_pkg::TX_IDLE;
						next_s.done = 1'b1;
					end
				end
			end
			default: next_s.st = uart_mdb_pkg::TX_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.st <= uart_mdb_pkg::TX_IDLE;
			s.line <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign txd = s.line;
	assign busy = (s.st != uart_mdb_pkg::TX_IDLE);
	assign done = s.done;
endmodule // uart_tx_shifter

// ===== tb/uart_mdb_monitor.sv
// checker of bus, pin and interrupt relations of the multidrop serial block
`timescale 1ns/1ps
module uart_mdb_monitor (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_pin_enable,
	input wire logic txd,
	input wire logic tx_pin_enable,
	input wire logic global_irq_enable,
	input wire logic rx_complete_irq,
	input wire logic tx_complete_irq,
	input wire logic tx_empty_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// both write halves meet an idle response channel
	sequence wr_taken;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	// read address accepted
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_taken |=> s_axi_bvalid)
		else $error("write response missing");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read response missing");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	aw_pair_a: assert property (s_axi_awready == s_axi_wready && !(s_axi_bvalid && s_axi_awready))
		else $error("write channels accepted apart");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read accepted");
	irq_gate_a: assert property (!global_irq_enable |-> !(rx_complete_irq || tx_complete_irq || tx_empty_irq))
		else $error("interrupt without global enable");
	rx_flush_a: assert property (!rx_pin_enable |=> !rx_complete_irq)
		else $error("receive data kept while disabled");
	tx_idle_a: assert property (!tx_pin_enable |-> txd)
		else $error("line not idle while transmitter off");
endmodule // uart_mdb_monitor

bind uart_mdb uart_mdb_monitor u_mon (.mclk(mclk), .resetn(resetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .rx_pin_enable(rx_pin_enable), .txd(txd),
	.tx_pin_enable(tx_pin_enable), .global_irq_enable(global_irq_enable),
	.rx_complete_irq(rx_complete_irq), .tx_complete_irq(tx_complete_irq),
	.tx_empty_irq(tx_empty_irq));

// ===== tb/serial_node.sv
// far serial node: feeds received frames and decodes the transmit line
`timescale 1ns/1ps
module serial_node (
	input wire logic mclk,
	input wire logic txd,
	input wire logic [4:0] bit_clks,
	output logic rx_start_detect,
	output logic rx_frame_valid,
	output uart_mdb_pkg::rx_frame_t rx_frame
);
	logic [7:0] seen[$]; // decoded transmit bytes
	logic [7:0] sh; // bits gathered so far
	initial begin
		rx_start_detect = 1'b0;
		rx_frame_valid = 1'b0;
		rx_frame = '0;
	end
	// one frame; type rides in data[8] or in the first stop bit
	task automatic send(input logic [8:0] d, input logic s, input logic p);
		@(posedge mclk);
		rx_frame_valid <= 1'b1;
		rx_frame <= '{data: d, stop_bit: s, parity_bit: p};
		@(posedge mclk);
		rx_frame_valid <= 1'b0;
		rx_frame <= ~{d, s, p}; // stale frame is not left on the wires
	endtask
	// a new start bit seen by the sampler
	task automatic start;
		@(posedge mclk);
		rx_start_detect <= 1'b1;
		@(posedge mclk);
		rx_start_detect <= 1'b0;
	endtask
	// sample every bit mid-way, least significant first; bad stop drops the byte
	always begin
		@(negedge txd);
		repeat (bit_clks / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(posedge mclk);
			sh[i] = txd;
		end
		repeat (bit_clks) @(posedge mclk);
		if (txd) seen.push_back(sh);
	end
endmodule // serial_node

// ===== tb/uart_mdb_tb_top.sv
// self-checking bench of the multidrop serial buffer and status block
`timescale 1ns/1ps
module uart_mdb_tb_top;
	localparam logic [7:0] DAT = uart_mdb_pkg::OFS_DATA;
	localparam logic [7:0] STA = uart_mdb_pkg::OFS_STATUS_A;
	localparam logic [7:0] CTB = uart_mdb_pkg::OFS_CONTROL_B;
	localparam logic [7:0] CTC = uart_mdb_pkg::OFS_CONTROL_C;
	logic mclk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic rx_start_detect, rx_frame_valid, rx_pin_enable, rx_sample_tick, txd, tx_pin_enable;
	logic global_irq_enable, tx_complete_irq_ack, rx_complete_irq, tx_complete_irq, tx_empty_irq;
	uart_mdb_pkg::rx_frame_t rx_frame;
	logic [4:0] bit_clks; // clocks per serial bit at baud 0
	int n_errors, samples_checked;
	uart_mdb u_dut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .rx_start_detect(rx_start_detect),
		.rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .rx_pin_enable(rx_pin_enable),
		.rx_sample_tick(rx_sample_tick), .txd(txd), .tx_pin_enable(tx_pin_enable),
		.global_irq_enable(global_irq_enable), .tx_complete_irq_ack(tx_complete_irq_ack),
		.rx_complete_irq(rx_complete_irq), .tx_complete_irq(tx_complete_irq),
		.tx_empty_irq(tx_empty_irq));
	serial_node u_node (.mclk(mclk), .txd(txd), .bit_clks(bit_clks),
		.rx_start_detect(rx_start_detect), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame));
	// free-running system clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask
	// one register write; ready is settled by the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(negedge mclk); while (s_axi_awready !== 1'b1);
		@(posedge mclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(negedge mclk); while (s_axi_bvalid !== 1'b1);
		wr_r = s_axi_bresp;
		// bready stays high, so a next call never re-drives it in one step
		@(posedge mclk);
	endtask
	// one register read into rd_v and rd_r
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge mclk); while (s_axi_arready !== 1'b1);
		@(posedge mclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge mclk); while (s_axi_rvalid !== 1'b1);
		rd_v = s_axi_rdata;
		rd_r = s_axi_rresp;
		@(posedge mclk);
	endtask
	// read and compare a byte register
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(rd_v, {24'h0, e});
	endtask
	// poll until the transmit-complete flag shows
	task automatic wait_txc;
		rd_v = '0;
		for (int i = 0; i < 300 && rd_v[6] !== 1'b1; i++) rd(STA);
	endtask
	// reset values and an unmapped place
	task automatic t_regs;
		rchk(STA, 8'h20);
		rchk(CTB, uart_mdb_pkg::RST_CONTROL_B);
		rchk(CTC, uart_mdb_pkg::RST_CONTROL_C);
		chk(rx_sample_tick, 1'b1);
		rd(8'h14);
		chk({30'h0, rd_r}, {30'h0, uart_mdb_pkg::RESP_SLVERR});
		chk(rd_v, 32'h0);
		wr(8'h14, 8'h00);
		chk({30'h0, wr_r}, {30'h0, uart_mdb_pkg::RESP_SLVERR});
		$display("end of register test");
	endtask
	// nine-bit frames under the address filter
	task automatic t_filter;
		wr(CTB, 8'h94);
		wr(STA, 8'h01);
		u_node.send(9'h0c3, 1'b1, 1'b0); // data type despite a high stop bit
		rchk(STA, 8'h21);
		u_node.send(9'h1a5, 1'b0, 1'b0); // address by ninth bit, low stop bit
		rchk(STA, 8'hb1);
		chk(rx_complete_irq, 1'b1);
		rchk(CTB, 8'h96);
		rchk(DAT, 8'ha5);
		wr(STA, 8'h00); // selected slave drops the filter
		u_node.send(9'h03c, 1'b1, 1'b0);
		rchk(DAT, 8'h3c);
		rchk(STA, 8'h20);
		$display("end of filter test");
	endtask
	// seven-bit frames: type from stop bit, upper bits, frame error
	task automatic t_short;
		wr(CTC, 8'h04);
		wr(CTB, 8'h10);
		wr(STA, 8'h01);
		u_node.send(9'h07f, 1'b0, 1'b0);
		rchk(STA, 8'h21);
		u_node.send(9'h1ff, 1'b1, 1'b0);
		rchk(DAT, 8'h7f);
		wr(STA, 8'h00);
		u_node.send(9'h055, 1'b0, 1'b0);
		rchk(STA, 8'hb0);
		rchk(DAT, 8'h55);
		rchk(STA, 8'h20);
		$display("end of short frame test");
	endtask
	// fifo depth, overrun, parity and receiver disable
	task automatic t_fifo;
		wr(CTC, 8'h26);
		u_node.send(9'h001, 1'b1, 1'b0);
		u_node.send(9'h002, 1'b1, 1'b1);
		u_node.send(9'h003, 1'b1, 1'b0);
		u_node.start();
		rchk(STA, 8'hac);
		rchk(DAT, 8'h01);
		rchk(STA, 8'ha0);
		rchk(DAT, 8'h02);
		rchk(DAT, 8'h03);
		rchk(STA, 8'h20);
		wr(CTC, 8'h06);
		u_node.send(9'h001, 1'b0, 1'b0);
		rchk(STA, 8'hb0);
		wr(CTB, 8'h00);
		rchk(STA, 8'h20);
		chk(rx_pin_enable, 1'b0);
		$display("end of fifo test");
	endtask
	// transmit with the filter set, a dropped write, completion
	task automatic t_tx;
		bit_clks = 5'd16;
		wr(STA, 8'h01);
		wr(CTB, 8'h48);
		wr(DAT, 8'h5a);
		wr(DAT, 8'h11);
		rchk(STA, 8'h01);
		wr(DAT, 8'h22); // buffer full: ignored
		wait_txc();
		rchk(STA, 8'h61);
		chk(tx_complete_irq, 1'b1);
		chk(32'(u_node.seen.size()), 32'd2);
		chk(u_node.seen[0], 8'h5a);
		chk(u_node.seen[1], 8'h11);
		wr(STA, 8'h41);
		rchk(STA, 8'h21);
		$display("end of transmit test");
	endtask
	// double speed, global gating, service acknowledge
	task automatic t_fast;
		bit_clks = 5'd8;
		wr(STA, 8'h02);
		wr(DAT, 8'hc3);
		wait_txc();
		chk(u_node.seen[2], 8'hc3);
		global_irq_enable <= 1'b0;
		@(negedge mclk);
		chk(tx_complete_irq, 1'b0);
		@(posedge mclk);
		global_irq_enable <= 1'b1;
		tx_complete_irq_ack <= 1'b1;
		@(posedge mclk);
		tx_complete_irq_ack <= 1'b0;
		rchk(STA, 8'h22);
		wr(CTB, 8'h28);
		chk(tx_empty_irq, 1'b1);
		$display("end of double speed test");
	endtask
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		conclude();
	end
	// main sequence
	initial begin
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		global_irq_enable = 1'b1;
		tx_complete_irq_ack = 1'b0;
		bit_clks = 5'd16;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		t_regs();
		t_filter();
		t_short();
		t_fifo();
		t_tx();
		t_fast();
		conclude();
	end
endmodule // uart_mdb_tb_top
